/* verilog/bpics_pkg.sv */
// constants and carrier types for the port identity and command/status registers
package bpics_pkg;
    // register byte offsets inside the port window
    localparam logic [11:0] OFS_IDENT = 12'h000;
    localparam logic [11:0] OFS_CMDSTAT = 12'h004;
    // identity field positions
    localparam int VID_LSB = 0;
    localparam int DID_LSB = 16;
    // command bit positions
    localparam int B_IO = 0;
    localparam int B_MEM = 1;
    localparam int B_FWD = 2;
    localparam int B_PAR = 6;
    localparam int B_SERR = 8;
    localparam int B_INTD = 10;
    // status bit positions (whole word)
    localparam int B_INTS = 19;
    localparam int B_CAP = 20;
    localparam int B_MDPE = 24;
    localparam int B_STA = 27;
    localparam int B_SSE = 30;
    localparam int B_DPE = 31;
    // index of each write-one-clear flag in the flag vector
    localparam int F_MDPE = 0;
    localparam int F_STA = 1;
    localparam int F_SSE = 2;
    localparam int F_DPE = 3;
    localparam int NFLAG = 4;
    localparam int FLAG_POS [NFLAG] = '{B_MDPE, B_STA, B_SSE, B_DPE};
    // writable command bits and reset values
    localparam logic [10:0] CMD_WMASK = 11'h547;
    localparam logic [10:0] CMD_RST = 11'h000;
    localparam logic [NFLAG-1:0] FLAG_RST = 4'h0;
    localparam logic CAP_RST = 1'b1;

    typedef enum logic [1:0] {
        ST_LOAD = 2'b01,
        ST_DONE = 2'b10
    } bpics_init_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } bpics_cfg_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } bpics_cfg_rsp_t;

    typedef struct packed {
        logic valid;
        logic [15:0] vendor;
        logic [15:0] device;
    } bpics_init_ld_t;

    typedef struct packed {
        logic valid;
        logic is_io;
        logic is_mem;
        logic is_cpl;
        logic poisoned;
        logic len_gt1;
    } bpics_pri_req_t;

    typedef struct packed {
        logic valid;
        logic is_memio;
        logic non_posted;
        logic poisoned;
        logic msg_or_cpl;
    } bpics_sec_req_t;

    typedef struct packed {
        logic pri_accept;
        logic pri_ignore;
        logic fwd_up;
        logic ur_cpl;
        logic intx_msg;
        logic err_msg;
    } bpics_act_t;
endpackage

/* verilog/bpics_regs.sv */
// port identity and command/status register pair with its gating logic
//
// Summary of operation
// - low identity half returns manufacturer code; init load may replace it, then read-only
// - high identity half returns part code; init load may replace it, then read-only
// - primary I/O accesses answered only while the I/O response bit is one
// - primary memory accesses answered only while the memory response bit is one
// - secondary non-posted memory/I/O refused as unsupported unless upstream forwarding is on
// - forwarding bit never holds back messages or completions
// - system-error reporting bit gates error messages and the signalled-error flag
// - interrupt-inhibit bit blocks legacy interrupt messages
// - unsupported command and status fields read zero, writes ignored
// - interrupt-pending bit follows the internal pending interrupt
// - capability-list bit always reads one
// - parity-response bit gates the master data parity flag on poisoned traffic
// - upstream port flags target abort on register access longer than one word
// - signalled-system-error flag set when an error message goes upstream
// - any poisoned primary packet sets the detected-parity flag
// - writing one clears a status flag, writing zero leaves it
// - identity fields frozen after init, restored only by fundamental reset
`timescale 1ns/100ps
module bpics_regs
    import bpics_pkg::*;
#(
    parameter logic [15:0] VENDOR_DFLT = 16'h1234, // arbitrary value
    parameter logic [15:0] DEVICE_DFLT = 16'h5678, // arbitrary value
    parameter bit IS_UPSTREAM = 1'b1
) (
    input wire logic clk_sys, // core clock
    input wire logic rst, // fundamental reset
    input wire logic hot_rst, // hot reset
    input wire bpics_init_ld_t init_ld, // identity load from eeprom
    input wire logic init_done, // initialization finished
    input wire bpics_cfg_req_t cfg_req, // configuration request
    output bpics_cfg_rsp_t cfg_rsp, // configuration answer
    input wire bpics_pri_req_t pri_req, // primary side request
    input wire bpics_sec_req_t sec_req, // secondary side request
    input wire logic intx_pending, // interrupt pending in port
    input wire logic intx_evt, // interrupt message wanted
    input wire logic err_evt, // fatal/nonfatal error detected
    output bpics_act_t act, // decisions, one-cycle pulses
    output logic [10:0] cmd_q, // command bits
    output logic init_frozen // identity now read-only
);
    bpics_init_t st_r;
    logic [15:0] vendor_r;
    logic [15:0] device_r;
    logic [10:0] cmd_r;
    logic [NFLAG-1:0] flag_r;
    logic [NFLAG-1:0] flag_set;
    logic [NFLAG-1:0] flag_clr;
    logic intp_r;
    bpics_cfg_rsp_t rsp_r;
    bpics_act_t act_r;
    bpics_act_t act_nxt;
    logic [31:0] stat_word;
    logic [31:0] rd_nxt;
    logic wr_cs;
    logic soft_rst;
    logic frozen_r;

    assign soft_rst = rst | hot_rst;
    assign wr_cs = cfg_req.valid & cfg_req.write & (cfg_req.addr == OFS_CMDSTAT);

    // init sequencing; load window closes for good
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r <= ST_LOAD;
        end else begin
            case (st_r)
                ST_LOAD: begin
                    if (init_done) begin
                        st_r <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    st_r <= ST_DONE;
                end
                default: begin
                    st_r <= ST_LOAD;
                end
            endcase
        end
    end

    // separate flop so the freeze output leaves a register, not a decode
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            frozen_r <= 1'b0;
        end else if (init_done) begin
            frozen_r <= 1'b1;
        end
    end

    // hot reset leaves identity alone
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            vendor_r <= VENDOR_DFLT;
            device_r <= DEVICE_DFLT;
        end else if (st_r == ST_LOAD && init_ld.valid) begin
            vendor_r <= init_ld.vendor;
            device_r <= init_ld.device;
        end
    end

    // only the writable command bits take software data
    always_ff @(posedge clk_sys) begin
        if (soft_rst) begin
            cmd_r <= CMD_RST;
        end else if (wr_cs) begin
            if (cfg_req.be[0]) begin
                cmd_r[7:0] <= cfg_req.wdata[7:0] & CMD_WMASK[7:0];
            end
            if (cfg_req.be[1]) begin
                cmd_r[10:8] <= cfg_req.wdata[10:8] & CMD_WMASK[10:8];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (soft_rst) begin
            intp_r <= 1'b0;
        end else begin
            intp_r <= intx_pending;
        end
    end

    // flag events
    always_comb begin
        flag_set = '0;
        flag_set[F_MDPE] = cmd_r[B_PAR] & ((sec_req.valid & sec_req.poisoned & sec_req.is_memio & cmd_r[B_FWD])
            | (pri_req.valid & pri_req.is_cpl & pri_req.poisoned));
        flag_set[F_STA] = IS_UPSTREAM & pri_req.valid & pri_req.is_mem & pri_req.len_gt1;
        flag_set[F_SSE] = cmd_r[B_SERR] & err_evt;
        flag_set[F_DPE] = pri_req.valid & pri_req.poisoned;
    end

    // all flags sit in the top byte lane
    genvar gi;
    generate
        for (gi = 0; gi < NFLAG; gi = gi + 1) begin : g_flag
            assign flag_clr[gi] = wr_cs & cfg_req.be[3] & cfg_req.wdata[FLAG_POS[gi]];
            always_ff @(posedge clk_sys) begin
                if (soft_rst) begin
                    flag_r[gi] <= FLAG_RST[gi];
                end else begin
                    flag_r[gi] <= (flag_r[gi] & ~flag_clr[gi]) | flag_set[gi];
                end
            end
        end
    endgenerate

    // unlisted bits stay zero on read
    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[10:0] = cmd_r;
        stat_word[B_INTS] = intp_r;
        stat_word[B_CAP] = CAP_RST;
        stat_word[B_MDPE] = flag_r[F_MDPE];
        stat_word[B_STA] = flag_r[F_STA];
        stat_word[B_SSE] = flag_r[F_SSE];
        stat_word[B_DPE] = flag_r[F_DPE];
    end

    // unmapped offsets read zero and accept writes silently
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (cfg_req.addr == OFS_IDENT) begin
            rd_nxt = {device_r, vendor_r};
        end else if (cfg_req.addr == OFS_CMDSTAT) begin
            rd_nxt = stat_word;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rsp_r <= '0;
        end else begin
            rsp_r.ack <= cfg_req.valid;
            rsp_r.rdata <= (cfg_req.valid & ~cfg_req.write) ? rd_nxt : 32'h0000_0000;
        end
    end

    // traffic decisions
    always_comb begin
        act_nxt = '0;
        act_nxt.pri_accept = pri_req.valid & ((pri_req.is_io & cmd_r[B_IO])
            | (pri_req.is_mem & cmd_r[B_MEM]) | pri_req.is_cpl);
        act_nxt.pri_ignore = pri_req.valid & ~pri_req.is_cpl & ((pri_req.is_io & ~cmd_r[B_IO])
            | (pri_req.is_mem & ~cmd_r[B_MEM]));
        act_nxt.fwd_up = sec_req.valid & (sec_req.msg_or_cpl | (sec_req.is_memio & cmd_r[B_FWD]));
        act_nxt.ur_cpl = sec_req.valid & ~sec_req.msg_or_cpl & sec_req.is_memio
            & ~cmd_r[B_FWD] & sec_req.non_posted;
        act_nxt.intx_msg = intx_evt & ~cmd_r[B_INTD];
        act_nxt.err_msg = err_evt & cmd_r[B_SERR];
    end

    always_ff @(posedge clk_sys) begin
        if (soft_rst) begin
            act_r <= '0;
        end else begin
            act_r <= act_nxt;
        end
    end

    // outputs straight from flops
    assign cfg_rsp = rsp_r;
    assign act = act_r;
    assign cmd_q = cmd_r;
    assign init_frozen = frozen_r;

    id_frozen_a: assert property (@(posedge clk_sys) disable iff (rst)
        st_r == ST_DONE |=> $stable(vendor_r) && $stable(device_r))
        else $error("identity changed after init");
    io_gate_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
        pri_req.valid && pri_req.is_io && !pri_req.is_cpl && !cmd_r[B_IO] |=> !act_r.pri_accept && act_r.pri_ignore)
        else $error("io access not ignored");
    mem_gate_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
        pri_req.valid && pri_req.is_mem && !pri_req.is_io && cmd_r[B_MEM] |=> act_r.pri_accept)
        else $error("memory access not answered");
    ur_refuse_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
        sec_req.valid && sec_req.is_memio && !sec_req.msg_or_cpl && sec_req.non_posted && !cmd_r[B_FWD]
        |=> act_r.ur_cpl && !act_r.fwd_up)
        else $error("unsupported request not refused");
    msg_pass_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
        sec_req.valid && sec_req.msg_or_cpl |=> act_r.fwd_up && !act_r.ur_cpl)
        else $error("message or completion held back");
    sse_cause_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
        !flag_r[F_SSE] ##1 flag_r[F_SSE] |-> $past(err_evt) && $past(cmd_r[B_SERR]))
        else $error("system error flag set without cause");
    intx_block_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
        act_r.intx_msg |-> $past(intx_evt) && !$past(cmd_r[B_INTD]))
        else $error("interrupt message while inhibited");
    rsvd_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
        cfg_req.valid && !cfg_req.write && cfg_req.addr == OFS_CMDSTAT
        |=> rsp_r.ack && rsp_r.rdata[18:11] == 8'h00 && rsp_r.rdata[29:28] == 2'b00
        && rsp_r.rdata[26:25] == 2'b00 && rsp_r.rdata[5:3] == 3'b000 && rsp_r.rdata[B_CAP])
        else $error("reserved status or capability bit wrong");
    mdpe_gate_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
        !cmd_r[B_PAR] && !flag_r[F_MDPE] |=> !flag_r[F_MDPE])
        else $error("parity flag set while response disabled");
    dpe_set_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
        pri_req.valid && pri_req.poisoned |=> flag_r[F_DPE])
        else $error("poisoned packet not flagged");
    set_wins_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
        |(flag_set & flag_clr) |=> (flag_r & $past(flag_set & flag_clr)) == $past(flag_set & flag_clr))
        else $error("new event lost to clear");
    zero_keeps_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
        flag_r[F_DPE] && !flag_clr[F_DPE] |=> flag_r[F_DPE])
        else $error("flag dropped without write of one");

    // identity, gating, command-mask, pending-bit and flag set/clear checks
    vendor_init_a: assert property (@(posedge clk_sys)
        rst |=> vendor_r == VENDOR_DFLT)
        else $error("manufacturer code not restored by reset");
    id_read_a: assert property (@(posedge clk_sys) disable iff (rst)
        cfg_req.valid && !cfg_req.write && cfg_req.addr == OFS_IDENT
        |=> rsp_r.rdata == {$past(device_r), $past(vendor_r)})
        else $error("identity read wrong");
    device_load_a: assert property (@(posedge clk_sys) disable iff (rst)
        st_r == ST_LOAD && init_ld.valid |=> device_r == $past(init_ld.device))
        else $error("part code load not taken");
    io_answer_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
        pri_req.valid && pri_req.is_io && !pri_req.is_mem && cmd_r[B_IO] |=> act_r.pri_accept && !act_r.pri_ignore)
        else $error("io access not answered");
    mem_ignore_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
        pri_req.valid && pri_req.is_mem && !pri_req.is_io && !pri_req.is_cpl && !cmd_r[B_MEM]
        |=> act_r.pri_ignore && !act_r.pri_accept)
        else $error("memory access not ignored");
    fwd_up_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
        sec_req.valid && sec_req.is_memio && cmd_r[B_FWD] |=> act_r.fwd_up && !act_r.ur_cpl)
        else $error("request not forwarded upstream");
    cpl_pass_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
        pri_req.valid && pri_req.is_cpl |=> act_r.pri_accept && !act_r.pri_ignore)
        else $error("completion held back");
    err_gate_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
        act_r.err_msg |-> $past(err_evt) && $past(cmd_r[B_SERR]))
        else $error("error message while reporting off");
    intx_pass_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
        intx_evt && !cmd_r[B_INTD] |=> act_r.intx_msg)
        else $error("interrupt message lost");
    cmd_mask_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
        wr_cs && cfg_req.be[0] |=> cmd_r[7:0] == ($past(cfg_req.wdata[7:0]) & CMD_WMASK[7:0]))
        else $error("low command byte not masked");
    intp_follow_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
        1'b1 |=> intp_r == $past(intx_pending))
        else $error("interrupt pending bit not following");
    mdpe_set_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
        cmd_r[B_PAR] && pri_req.valid && pri_req.is_cpl && pri_req.poisoned |=> flag_r[F_MDPE])
        else $error("poisoned completion not flagged");
    sta_set_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
        IS_UPSTREAM && pri_req.valid && pri_req.is_mem && pri_req.len_gt1 |=> flag_r[F_STA])
        else $error("long register access not flagged");
    sse_set_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
        err_evt && cmd_r[B_SERR] |=> flag_r[F_SSE])
        else $error("error message not flagged");
    one_clears_a: assert property (@(posedge clk_sys) disable iff (soft_rst)
        wr_cs && cfg_req.be[3] && cfg_req.wdata[B_DPE] && !flag_set[F_DPE] |=> !flag_r[F_DPE])
        else $error("write of one did not clear flag");
    hot_keeps_a: assert property (@(posedge clk_sys) disable iff (rst)
        hot_rst && !init_ld.valid |=> $stable(vendor_r) && $stable(device_r))
        else $error("identity changed by hot reset");
endmodule

/* bench/bpics_rc_model.sv */
// root complex model issuing configuration requests and port traffic
`timescale 1ns/100ps
module bpics_rc_model
    import bpics_pkg::*;
(
    input wire logic clk_sys, // core clock
    output bpics_cfg_req_t cfg_req, // configuration request
    input wire bpics_cfg_rsp_t cfg_rsp, // configuration answer
    input wire bpics_act_t act, // port decisions
    output bpics_pri_req_t pri_req, // primary packet
    output bpics_sec_req_t sec_req, // secondary packet
    output logic intx_evt, // interrupt message wanted
    output logic err_evt // error detected
);
    initial begin
        cfg_req = '0;
        pri_req = '0;
        sec_req = '0;
        intx_evt = 1'b0;
        err_evt = 1'b0;
    end

    // one request cycle; answer taken at the following edge while it still stands
    task automatic cyc(input bpics_cfg_req_t rq, input bpics_pri_req_t p, input bpics_sec_req_t s,
        input logic ie, input logic ee, output bpics_cfg_rsp_t rs, output bpics_act_t a);
        @(posedge clk_sys);
        cfg_req <= rq;
        pri_req <= p;
        sec_req <= s;
        intx_evt <= ie;
        err_evt <= ee;
        @(posedge clk_sys);
        cfg_req <= '0;
        pri_req <= '0;
        sec_req <= '0;
        intx_evt <= 1'b0;
        err_evt <= 1'b0;
        @(posedge clk_sys);
        rs = cfg_rsp;
        a = act;
    endtask
endmodule

/* bench/tb_bridge_port_id_command_status.sv */
// self-checking bench for the port identity and command/status registers
`timescale 1ns/100ps
module tb_bridge_port_id_command_status;
    import bpics_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic hot_rst = 1'b0;
    bpics_init_ld_t init_ld = '0;
    logic init_done = 1'b0;
    logic intx_pending = 1'b0;
    bpics_cfg_req_t cfg_req;
    bpics_cfg_rsp_t cfg_rsp;
    bpics_pri_req_t pri_req;
    bpics_sec_req_t sec_req;
    logic intx_evt;
    logic err_evt;
    bpics_act_t act;
    logic [10:0] cmd_q;
    logic init_frozen;
    bpics_cfg_rsp_t rs;
    bpics_act_t a;
    int fail_count = 0;
    int n_compared = 0;
    int cyc_count = 0;
    // traffic table: primary, secondary, expected with command 0 and with 0x547
    logic [5:0] tp [7] = '{6'h30, 6'h28, 6'h24, 6'h00, 6'h00, 6'h00, 6'h00};
    logic [4:0] ts [7] = '{5'h00, 5'h00, 5'h00, 5'h1C, 5'h19, 5'h00, 5'h00};
    logic [5:0] e0 [7] = '{6'h10, 6'h10, 6'h20, 6'h04, 6'h08, 6'h02, 6'h00};
    logic [5:0] e1 [7] = '{6'h20, 6'h20, 6'h20, 6'h08, 6'h08, 6'h00, 6'h01};

    bpics_regs #(.VENDOR_DFLT(16'h1234), .DEVICE_DFLT(16'h5678), .IS_UPSTREAM(1'b1)) bpics_regs_i (.clk_sys(clk_sys),
        .rst(rst), .hot_rst(hot_rst), .init_ld(init_ld),
        .init_done(init_done), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .pri_req(pri_req), .sec_req(sec_req),
        .intx_pending(intx_pending), .intx_evt(intx_evt), .err_evt(err_evt), .act(act), .cmd_q(cmd_q),
        .init_frozen(init_frozen));
    bpics_rc_model bpics_rc_model_i (.clk_sys(clk_sys), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .act(act),
        .pri_req(pri_req), .sec_req(sec_req), .intx_evt(intx_evt), .err_evt(err_evt));

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic final_report;
        if (fail_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // a hang is cut short well after the sequence should have ended
    always @(posedge clk_sys) begin
        cyc_count++;
        if (cyc_count == 3000) begin
            fail_count++;
            final_report;
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic bpics_cfg_req_t rq(logic w, logic [11:0] ad, logic [3:0] be, logic [31:0] d);
        return '{1'b1, w, ad, be, d};
    endfunction

    task automatic rd(input string nm, input logic [11:0] ad, input logic [31:0] exp);
        bpics_rc_model_i.cyc(rq(1'b0, ad, 4'h0, 32'h0), '0, '0, 1'b0, 1'b0, rs, a);
        chk(nm, rs.rdata, exp);
    endtask

    task automatic wr(input logic [11:0] ad, input logic [3:0] be, input logic [31:0] d);
        bpics_rc_model_i.cyc(rq(1'b1, ad, be, d), '0, '0, 1'b0, 1'b0, rs, a);
        chk("write ack", {31'h0, rs.ack}, 32'h1);
    endtask

    task automatic tr(input logic [5:0] p, input logic [4:0] s, input logic ie, input logic ee,
        input logic [5:0] exp);
        bpics_rc_model_i.cyc('0, bpics_pri_req_t'(p), bpics_sec_req_t'(s), ie, ee, rs, a);
        chk("act", {26'h0, a}, {26'h0, exp});
    endtask

    task automatic traffic(input bit on);
        for (int k = 0; k < 7; k++) begin
            tr(tp[k], ts[k], k == 5, k == 6, on ? e1[k] : e0[k]);
        end
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        rd("ident default", OFS_IDENT, 32'h5678_1234);
        chk("not frozen", {31'h0, init_frozen}, 32'h0);
        @(posedge clk_sys);
        init_ld <= '{1'b1, 16'hA5A5, 16'h5A5A};
        @(posedge clk_sys);
        init_ld <= '0;
        init_done <= 1'b1;
        @(posedge clk_sys);
        // a load after the freeze must not land
        init_done <= 1'b0;
        init_ld <= '{1'b1, 16'h1111, 16'h2222};
        @(posedge clk_sys);
        init_ld <= '0;
        rd("ident loaded", OFS_IDENT, 32'h5A5A_A5A5);
        chk("frozen", {31'h0, init_frozen}, 32'h1);
        wr(OFS_IDENT, 4'hF, 32'hFFFF_FFFF);
        rd("ident write", OFS_IDENT, 32'h5A5A_A5A5);
        rd("status reset", OFS_CMDSTAT, 32'h0010_0000);
        rd("unmapped", 12'h008, 32'h0);
        traffic(1'b0);
        wr(OFS_CMDSTAT, 4'h7, 32'hFFFF_FFFF);
        rd("cmd bits", OFS_CMDSTAT, 32'h0010_0547);
        chk("cmd_q", {21'h0, cmd_q}, {21'h0, CMD_WMASK});
        traffic(1'b1);
        rd("sys err flag", OFS_CMDSTAT, 32'h4010_0547);
        tr(6'h26, 5'h00, 1'b0, 1'b0, 6'h20);
        tr(6'h29, 5'h00, 1'b0, 1'b0, 6'h20);
        tr(6'h00, 5'h1A, 1'b0, 1'b0, 6'h08);
        rd("all flags", OFS_CMDSTAT, 32'hC910_0547);
        wr(OFS_CMDSTAT, 4'h8, 32'h0000_0000);
        rd("write zero", OFS_CMDSTAT, 32'hC910_0547);
        wr(OFS_CMDSTAT, 4'h4, 32'hFFFF_FFFF);
        rd("lane two", OFS_CMDSTAT, 32'hC910_0547);
        wr(OFS_CMDSTAT, 4'h8, 32'hFF00_0000);
        rd("cleared", OFS_CMDSTAT, 32'h0010_0547);
        // clearing write and new poisoned completion in the same cycle
        bpics_rc_model_i.cyc(rq(1'b1, OFS_CMDSTAT, 4'h8, 32'hFF00_0000), bpics_pri_req_t'(6'h26), '0,
            1'b0, 1'b0, rs, a);
        rd("set wins", OFS_CMDSTAT, 32'h8110_0547);
        @(posedge clk_sys);
        intx_pending <= 1'b1;
        @(posedge clk_sys);
        rd("intx pending", OFS_CMDSTAT, 32'h8118_0547);
        @(posedge clk_sys);
        intx_pending <= 1'b0;
        hot_rst <= 1'b1;
        @(posedge clk_sys);
        hot_rst <= 1'b0;
        rd("hot ident", OFS_IDENT, 32'h5A5A_A5A5);
        rd("hot status", OFS_CMDSTAT, 32'h0010_0000);
        chk("cmd_q hot", {21'h0, cmd_q}, 32'h0);
        wr(OFS_CMDSTAT, 4'h3, 32'h0000_0001);
        tr(6'h26, 5'h00, 1'b0, 1'b1, 6'h20);
        rd("gated flags", OFS_CMDSTAT, 32'h8010_0001);
        final_report;
    end
endmodule
